// file: core/rstcr_pkg.sv
// Package: register map, fields, codes and timing of the reset controller register block
package rstcr_pkg;
   localparam logic [3:0]  OFF_COMMAND    = 4'h0;
   localparam logic [3:0]  OFF_STATUS     = 4'h4;
   localparam logic [3:0]  OFF_MODE       = 4'h8;
   localparam logic [7:0]  PASSWORD       = 8'hA5;
   localparam int          KEY_LSB        = 24;
   localparam int          CMD_CPU_BIT    = 0;
   localparam int          CMD_PERIPH_BIT = 2;
   localparam int          CMD_PIN_BIT    = 3;
   localparam int          ST_EDGE_BIT    = 0;
   localparam int          ST_BROWN_BIT   = 1;
   localparam int          ST_CAUSE_LSB   = 8;
   localparam int          ST_LEVEL_BIT   = 16;
   localparam int          ST_BUSY_BIT    = 17;
   localparam int          MD_PIN_EN_BIT  = 0;
   localparam int          MD_EDGE_IE_BIT = 4;
   localparam int          MD_LEN_LSB     = 8;
   localparam int          MD_BROWN_IE_BIT = 16;
   localparam logic [2:0]  CAUSE_POWER    = 3'h0;
   localparam logic [2:0]  CAUSE_WATCHDOG = 3'h2;
   localparam logic [2:0]  CAUSE_SOFT     = 3'h3;
   localparam logic [2:0]  CAUSE_USER     = 3'h4;
   localparam logic [2:0]  CAUSE_BROWN    = 3'h5;
   localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
   localparam int          SYNC_CYCLES    = 2;
   localparam int          START_CYCLES   = 3;
   localparam int          SOFT_CYCLES    = 3;
   typedef struct packed {
      logic       cpu;
      logic       periph;
      logic       pin;
   } rstcr_req_t;
   typedef struct packed {
      logic       brown_ie;
      logic [3:0] len_exp;
      logic       edge_ie;
      logic       pin_en;
   } rstcr_mode_t;
endpackage : rstcr_pkg

// file: core/rstcr_sync.sv
// Two-flop synchroniser for a single asynchronous level
`timescale 1ns/10ps
module rstcr_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic clk_i,   // Clock
   input  wire logic rst_i,   // Synchronous reset
   input  wire logic d_i,     // Asynchronous level
   output logic      q_o      // Synchronised level
);
   logic meta_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RESET_VAL;
         q_o    <= RESET_VAL;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : rstcr_sync

// file: core/rstcr_slow_timer.sv
// Slow-clock tick counter: counts a loaded length of ticks down, flags done
`timescale 1ns/10ps
module rstcr_slow_timer #(
   parameter int W = 17
) (
   input  wire logic         clk_i,    // Clock
   input  wire logic         rst_i,    // Synchronous reset
   input  wire logic         load_i,   // Load a new length and start
   input  wire logic [W-1:0] len_i,    // Length in slow ticks
   input  wire logic         tick_i,   // Slow clock tick pulse
   output logic              run_o     // High while counting
);
   logic [W-1:0] cnt_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         run_o <= 1'b0;
      end else if (load_i) begin
         cnt_r <= len_i;
         run_o <= 1'b1;
      end else if (run_o && tick_i) begin
         cnt_r <= cnt_r - W'(1);
         run_o <= (cnt_r != W'(1));
      end
   end
endmodule : rstcr_slow_timer

// file: core/rstcr_regs.sv
// Reset controller register block: command, status and mode over classic Wishbone
//
// Contract
// - Command and mode writes need key 0xA5 in top byte, else discarded.
// - Command bit 0 with valid key resets processor; zero does nothing.
// - Command bit 2 with valid key resets peripherals; zero does nothing.
// - Command bit 3 with valid key drives reset pin low.
// - Status bit 0 set by pin falling edge, cleared by status read.
// - Status bit 1 set by brownout falling edge, cleared by status read.
// - Status bits 10..8 hold last processor reset cause; reads keep it.
// - Causes: 000 power-up, 010 watchdog, 011 software, 100 pin, 101 brownout; block never loads 101, a brownout only sets status bit 1.
// - Status bit 16 shows pin level sampled on master clock.
// - Status bit 17 is one while a software command runs.
// - Mode bit 0 set lets pin low start a user reset.
// - Mode bit 4 with user reset off routes edge flag to interrupt.
// - Mode bit 16 routes brownout flag to interrupt.
// - Pin pulse lasts 2^(length+1) slow cycles; length at mode bits 11..8.
// - Command writes ignored while a command is in progress.
// - Cause field updated by software only when processor bit set.
// - Pin low from own pin command is not a user reset.
// - User reset ends 2+3 slow cycles after pin rises, loads code 100.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module rstcr_regs #(
   parameter int LEN_W = 17
) (
   input  wire logic        clk_i,          // Master clock, 250 MHz
   input  wire logic        rst_i,          // Synchronous reset, active high
   input  wire logic        cyc_i,          // Wishbone cycle
   input  wire logic        stb_i,          // Wishbone strobe
   input  wire logic        we_i,           // Wishbone write enable
   input  wire logic [3:0]  adr_i,          // Wishbone byte address
   input  wire logic [3:0]  sel_i,          // Wishbone byte selects
   input  wire logic [31:0] dat_i,          // Wishbone write data
   output logic      [31:0] dat_o,          // Wishbone read data
   output logic             ack_o,          // Wishbone acknowledge
   input  wire logic        slow_clk_i,     // Slow clock, asynchronous
   input  wire logic        brownout_i,     // Brownout detector output, asynchronous
   input  wire logic        watchdog_i,     // Watchdog fault pulse, same clock
   input  wire logic        pin_level_i,    // External reset pin input
   output logic             pin_level_o,    // Reset pin output value, always 0
   output logic             pin_level_oe_o, // Reset pin output enable, high drives low
   output logic             cpu_reset_o,    // Processor reset, active high
   output logic             periph_reset_o, // Peripheral reset, active high
   output logic             irq_o           // Controller interrupt
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_IDLE, ST_SOFT, ST_USER_LOW, ST_USER_REL} rstcr_state_t;

   rstcr_state_t         state_r, state_nxt;
   rstcr_pkg::rstcr_mode_t mode_r;
   rstcr_pkg::rstcr_req_t  req_r;
   logic [2:0]           cause_r;
   logic                 edge_flag_r, brown_flag_r;
   logic                 pin_prev_r, brown_prev_r, slow_prev_r;
   logic                 pin_s, brown_s, slow_s;
   logic [2:0]           rel_cnt_r;
   logic                 ack_r;
   logic [31:0]          rdata_r;

   // Pin, brownout and slow clock come from outside; two flops each
   rstcr_sync #(.RESET_VAL(1'b1)) u_pin_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(pin_level_i), .q_o(pin_s));
   rstcr_sync #(.RESET_VAL(1'b1)) u_bod_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(brownout_i), .q_o(brown_s));
   rstcr_sync #(.RESET_VAL(1'b0)) u_slk_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(slow_clk_i), .q_o(slow_s));

   ////////////////////////////////////////////////////////////////////////////
   // Shared decode helpers
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      return a == off;
   endfunction : hit

   // High-to-low step between two samples of a synchronised level
   function automatic logic fell(input logic prev_v, input logic cur_v);
      return prev_v && !cur_v;
   endfunction : fell

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        req_w      = cyc_i && stb_i && !ack_r;
   wire        key_ok     = (dat_i[31:24] == rstcr_pkg::PASSWORD) && (sel_i == 4'hF);
   wire        wr_cmd     = req_w && we_i && hit(adr_i, rstcr_pkg::OFF_COMMAND) && key_ok;
   wire        wr_mode    = req_w && we_i && hit(adr_i, rstcr_pkg::OFF_MODE) && key_ok;
   wire        rd_status  = req_w && !we_i && hit(adr_i, rstcr_pkg::OFF_STATUS);
   wire        busy       = (state_r == ST_SOFT);
   wire        cmd_take   = wr_cmd && !busy && (state_r == ST_IDLE) &&
                            (dat_i[rstcr_pkg::CMD_CPU_BIT] || dat_i[rstcr_pkg::CMD_PERIPH_BIT] ||
                             dat_i[rstcr_pkg::CMD_PIN_BIT]);
   wire        cmd_cpu    = cmd_take && dat_i[rstcr_pkg::CMD_CPU_BIT];
   wire        cmd_per    = cmd_take && dat_i[rstcr_pkg::CMD_PERIPH_BIT];
   wire        cmd_pin    = cmd_take && dat_i[rstcr_pkg::CMD_PIN_BIT];
   wire        slow_tick  = slow_s && !slow_prev_r;
   wire        pin_fall   = fell(pin_prev_r, pin_s);
   wire        brown_fall = fell(brown_prev_r, brown_s);
   wire        pulse_run;
   wire        soft_run;
   wire [LEN_W-1:0] pulse_len = LEN_W'(1) << (LEN_W'(mode_r.len_exp) + LEN_W'(1));

   wire [31:0] status_w = {14'h0000, busy, pin_s, 5'h00, cause_r, 6'h00, brown_flag_r, edge_flag_r};
   wire [31:0] mode_w   = {15'h0000, mode_r.brown_ie, 4'h0, mode_r.len_exp, 3'h0, mode_r.edge_ie,
                           3'h0, mode_r.pin_en};
   wire [31:0] rdata_w  = we_i ? 32'h0000_0000 :
                          hit(adr_i, rstcr_pkg::OFF_STATUS) ? status_w :
                          hit(adr_i, rstcr_pkg::OFF_MODE)   ? mode_w   : 32'h0000_0000;

   // Own pin pulse masks pin-low detection so it never becomes a user reset
   wire        user_start = mode_r.pin_en && !pin_s && !pulse_run && !req_r.pin &&
                            (state_r == ST_IDLE) && !cmd_take;

   rstcr_slow_timer #(.W(LEN_W)) u_pulse (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (cmd_pin),
      .len_i  (pulse_len),
      .tick_i (slow_tick),
      .run_o  (pulse_run)
   );
   rstcr_slow_timer #(.W(LEN_W)) u_soft (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (cmd_take),
      .len_i  (LEN_W'(rstcr_pkg::SOFT_CYCLES)),
      .tick_i (slow_tick),
      .run_o  (soft_run)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reset state machine
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:     if (cmd_take) begin
                         state_nxt = ST_SOFT;
                      end else if (user_start) begin
                         state_nxt = ST_USER_LOW;
                      end
         // Stay busy until our own pulse reads high again, else its tail looks like a user reset
         ST_SOFT:     if (!soft_run && !pulse_run && (pin_s || !req_r.pin)) begin
                         state_nxt = ST_IDLE;
                      end
         ST_USER_LOW: if (pin_s) begin
                         state_nxt = ST_USER_REL;
                      end
         ST_USER_REL: if (!pin_s) begin
                         state_nxt = ST_USER_LOW;
                      end else if (slow_tick && rel_cnt_r == 3'(rstcr_pkg::SYNC_CYCLES + rstcr_pkg::START_CYCLES - 1)) begin
                         state_nxt = ST_IDLE;
                      end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         rel_cnt_r <= 3'h0;
      end else begin
         state_r   <= state_nxt;
         rel_cnt_r <= (state_r == ST_USER_REL && pin_s) ? rel_cnt_r + 3'(slow_tick) : 3'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_r <= '0;
      end else if (cmd_take) begin
         req_r <= '{cpu: cmd_cpu, periph: cmd_per, pin: cmd_pin};
      end else if (state_r == ST_SOFT && state_nxt == ST_IDLE) begin
         req_r <= '0;
      end
   end

   // Cause field: loaded by a watchdog pulse or on release, never touched by reads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_r <= rstcr_pkg::CAUSE_POWER;
      end else if (watchdog_i) begin
         cause_r <= rstcr_pkg::CAUSE_WATCHDOG;
      end else if (state_r == ST_SOFT && state_nxt == ST_IDLE && req_r.cpu) begin
         cause_r <= rstcr_pkg::CAUSE_SOFT;
      end else if (state_r == ST_USER_REL && state_nxt == ST_IDLE) begin
         cause_r <= rstcr_pkg::CAUSE_USER;
      end
   end

   // Sticky flags: a new event wins over the clearing read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_flag_r  <= 1'b0;
         brown_flag_r <= 1'b0;
         pin_prev_r   <= 1'b1;
         brown_prev_r <= 1'b1;
         slow_prev_r  <= 1'b0;
      end else begin
         edge_flag_r  <= pin_fall || (edge_flag_r && !rd_status);
         brown_flag_r <= brown_fall || (brown_flag_r && !rd_status);
         pin_prev_r   <= pin_s;
         brown_prev_r <= brown_s;
         slow_prev_r  <= slow_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= '{brown_ie: rstcr_pkg::MODE_RESET[rstcr_pkg::MD_BROWN_IE_BIT],
                     len_exp:  rstcr_pkg::MODE_RESET[rstcr_pkg::MD_LEN_LSB +: 4],
                     edge_ie:  rstcr_pkg::MODE_RESET[rstcr_pkg::MD_EDGE_IE_BIT],
                     pin_en:   rstcr_pkg::MODE_RESET[rstcr_pkg::MD_PIN_EN_BIT]};
      end else if (wr_mode) begin
         mode_r <= '{brown_ie: dat_i[rstcr_pkg::MD_BROWN_IE_BIT],
                     len_exp:  dat_i[rstcr_pkg::MD_LEN_LSB +: 4],
                     edge_ie:  dat_i[rstcr_pkg::MD_EDGE_IE_BIT],
                     pin_en:   dat_i[rstcr_pkg::MD_PIN_EN_BIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one cycle after the request, read data registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= req_w;
         rdata_r <= req_w ? rdata_w : 32'h0000_0000;
      end
   end

   assign ack_o          = ack_r;
   assign dat_o          = rdata_r;
   assign pin_level_o    = 1'b0;
   assign pin_level_oe_o = pulse_run;
   assign cpu_reset_o    = (state_r == ST_SOFT && req_r.cpu) || state_r == ST_USER_LOW ||
                           state_r == ST_USER_REL;
   assign periph_reset_o = (state_r == ST_SOFT && req_r.periph) || state_r == ST_USER_LOW ||
                           state_r == ST_USER_REL;
   assign irq_o          = (edge_flag_r && mode_r.edge_ie && !mode_r.pin_en) ||
                           (brown_flag_r && mode_r.brown_ie);

   ////////////////////////////////////////////////////////////////////////////
   // Checks on what the block drives; all wait for reset to be released
   mode_key_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req_w && we_i && adr_i == rstcr_pkg::OFF_MODE && dat_i[31:24] != rstcr_pkg::PASSWORD) |=> $stable(mode_r))
      else $error("mode changed without key");
   cmd_key_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req_w && we_i && adr_i == rstcr_pkg::OFF_COMMAND && dat_i[31:24] != rstcr_pkg::PASSWORD) |-> !cmd_take)
      else $error("command taken without key");
   cmd_busy_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cmd_take |=> busy && req_r.cpu == $past(cmd_cpu) && req_r.pin == $past(cmd_pin))
      else $error("command not started");
   busy_ignore_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (busy && wr_cmd && state_nxt == ST_SOFT) |=> $stable(req_r))
      else $error("command taken while busy");
   flag_set_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pin_fall |=> edge_flag_r)
      else $error("edge flag not set");
   flag_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_status && !pin_fall) |=> !edge_flag_r)
      else $error("edge flag kept after read");
   brown_set_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      brown_fall |=> brown_flag_r)
      else $error("brownout flag not set");
   cause_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_status && !watchdog_i && state_r == ST_IDLE) |=> $stable(cause_r))
      else $error("read altered cause");
   soft_cause_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_SOFT && state_nxt == ST_IDLE && !req_r.cpu && !watchdog_i) |=> $stable(cause_r))
      else $error("cause set without processor bit");
   user_cause_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_USER_REL && state_nxt == ST_IDLE && !watchdog_i) |=> cause_r == rstcr_pkg::CAUSE_USER)
      else $error("user cause not loaded");
   user_entry_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && mode_r.pin_en && !pin_s && !cmd_take) |=> state_r == ST_USER_LOW)
      else $error("pin low did not start user reset");
   user_block_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !mode_r.pin_en) |=> state_r != ST_USER_LOW)
      else $error("user reset while disabled");
   irq_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_status && !pin_fall && !brown_fall) |=> !irq_o)
      else $error("irq stayed after read");
   irq_mask_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (mode_r.pin_en && !(brown_flag_r && mode_r.brown_ie)) |-> !irq_o)
      else $error("edge irq while user reset on");
   pin_drive_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cmd_pin |=> pin_level_oe_o [*2])
      else $error("pin pulse too short");
   own_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && $past(state_r) == ST_SOFT && $past(req_r.pin)) |-> pin_s)
      else $error("left command while own pulse still low");
   pin_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_r && $past(rd_status)) |-> dat_o[rstcr_pkg::ST_LEVEL_BIT] == $past(pin_s))
      else $error("pin level wrong");
endmodule : rstcr_regs

// file: verification/rstcr_pin_model.sv
// Board model of the open-drain reset pin: pull-up plus a push button
`timescale 1ns/10ps
module rstcr_pin_model (
   input  wire logic drive_i,   // Device output enable
   input  wire logic value_i,   // Device output value
   input  wire logic button_i,  // Board pulls the pin low
   output logic      pin_o      // Resolved pin level
);
   // The pull-up wins whenever nobody pulls low, so a released pin never keeps a stale level
   assign pin_o = ((drive_i && !value_i) || button_i) ? 1'b0 : 1'b1;
endmodule : rstcr_pin_model

// file: verification/tb_top.sv
// Self-checking bench for the reset controller register block
`timescale 1ns/10ps
module tb_top;
   logic        clk_i, rst_i, cyc, stb, we, slow_clk, brownout, watchdog, button, pin;
   logic        pin_out, pin_oe, cpu_rst, per_rst, irq, ack;
   logic [3:0]  adr, sel, wsel;
   logic [31:0] wdat, rdat, q;
   int          miscompares, n_checks, cycles;

   rstcr_regs rstcr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .slow_clk_i(slow_clk), .brownout_i(brownout),
      .watchdog_i(watchdog), .pin_level_i(pin), .pin_level_o(pin_out), .pin_level_oe_o(pin_oe),
      .cpu_reset_o(cpu_rst), .periph_reset_o(per_rst), .irq_o(irq));
   rstcr_pin_model rstcr_pin_model_i (.drive_i(pin_oe), .value_i(pin_out), .button_i(button), .pin_o(pin));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Slow clock scaled to 40 master cycles so pulse lengths stay short
   initial begin
      slow_clk = 1'b0;
      forever #80 slow_clk = ~slow_clk;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Classic single cycle; ack and read data are taken at the rising edge that samples ack high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= wsel;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   // A hang here is ended by the cycle ceiling
   task automatic poll_idle();
      do begin
         wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      end while (q[rstcr_pkg::ST_BUSY_BIT] !== 1'b0);
   endtask : poll_idle
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("status reset", q, 32'h0001_0000);
      wb(1'b0, rstcr_pkg::OFF_MODE, 32'h0);
      chk("mode reset", q, rstcr_pkg::MODE_RESET);
      wb(1'b0, 4'hC, 32'h0);
      chk("unmapped read", q, 32'h0);
   endtask : s_reset
   task automatic s_mode();
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'h5A00_0F11);
      wb(1'b0, rstcr_pkg::OFF_MODE, 32'h0);
      chk("mode bad key", q, 32'h0);
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'hA5FF_FFFF);
      wb(1'b0, rstcr_pkg::OFF_MODE, 32'h0);
      chk("mode fields", q, 32'h0001_0F11);
      wsel = 4'h7;
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'hA500_0000);
      wsel = 4'hF;
      wb(1'b0, rstcr_pkg::OFF_MODE, 32'h0);
      chk("mode partial sel", q, 32'h0001_0F11);
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'hA500_0101);
   endtask : s_mode
   task automatic s_soft();
      wb(1'b1, rstcr_pkg::OFF_COMMAND, 32'h5A00_0001);
      @(negedge clk_i);
      chk("cpu reset bad key", cpu_rst, 32'h0);
      wb(1'b1, rstcr_pkg::OFF_COMMAND, 32'hA500_0001);
      @(negedge clk_i);
      chk("cpu reset", cpu_rst, 32'h1);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("busy", q, 32'h0003_0000);
      poll_idle();
      chk("soft cause", q, 32'h0001_0300);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("cause kept", q, 32'h0001_0300);
      chk("cpu released", cpu_rst, 32'h0);
   endtask : s_soft
   // Pin plus peripheral command with length 1, a processor command while busy
   task automatic s_pin();
      int   edges;
      logic prev, cpu_seen;
      @(posedge slow_clk);
      repeat (10) @(posedge clk_i);
      wb(1'b1, rstcr_pkg::OFF_COMMAND, 32'hA500_000C);
      @(negedge clk_i);
      chk("periph reset", per_rst, 32'h1);
      chk("pin driven", pin_oe, 32'h1);
      wb(1'b1, rstcr_pkg::OFF_COMMAND, 32'hA500_0001);
      edges    = 0;
      prev     = slow_clk;
      cpu_seen = cpu_rst;
      while (pin_oe === 1'b1) begin
         @(posedge clk_i);
         if (slow_clk && !prev) edges++;
         prev     = slow_clk;
         cpu_seen = cpu_seen | cpu_rst;
      end
      chk("pulse ticks", edges, 32'd4);
      chk("no cpu reset", cpu_seen, 32'h0);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("edge flag", q[rstcr_pkg::ST_EDGE_BIT], 32'h1);
      poll_idle();
      chk("cause unchanged", q, 32'h0001_0300);
      chk("periph released", per_rst, 32'h0);
   endtask : s_pin
   task automatic s_irq();
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'hA501_0010);
      button <= 1'b1;
      repeat (20) @(posedge clk_i);
      button <= 1'b0;
      repeat (10) @(negedge clk_i);
      chk("edge irq", irq, 32'h1);
      chk("no user reset", cpu_rst, 32'h0);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("edge status", q, 32'h0001_0301);
      @(negedge clk_i);
      chk("irq cleared", irq, 32'h0);
      @(posedge clk_i);
      brownout <= 1'b0;
      repeat (10) @(negedge clk_i);
      chk("brownout irq", irq, 32'h1);
      @(posedge clk_i);
      brownout <= 1'b1;
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("brownout status", q, 32'h0001_0302);
      @(negedge clk_i);
      chk("irq cleared again", irq, 32'h0);
   endtask : s_irq
   task automatic s_user();
      wb(1'b1, rstcr_pkg::OFF_MODE, 32'hA500_0011);
      button <= 1'b1;
      repeat (30) @(negedge clk_i);
      chk("user reset", cpu_rst, 32'h1);
      chk("edge irq masked", irq, 32'h0);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("pin level low", q[rstcr_pkg::ST_LEVEL_BIT], 32'h0);
      button <= 1'b0;
      while (cpu_rst !== 1'b0) begin
         @(posedge clk_i);
      end
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("user cause", q, 32'h0001_0400);
   endtask : s_user
   task automatic s_wdog();
      @(posedge clk_i);
      watchdog <= 1'b1;
      @(posedge clk_i);
      watchdog <= 1'b0;
      repeat (400) @(posedge clk_i);
      wb(1'b0, rstcr_pkg::OFF_STATUS, 32'h0);
      chk("watchdog cause", q[10:8], 32'(rstcr_pkg::CAUSE_WATCHDOG));
   endtask : s_wdog
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc         = 1'b0;
      stb         = 1'b0;
      we          = 1'b0;
      adr         = 4'h0;
      sel         = 4'h0;
      wsel        = 4'hF;
      wdat        = 32'h0;
      brownout    = 1'b1;
      watchdog    = 1'b0;
      button      = 1'b0;
      rst_i       = 1'b1;
      miscompares = 0;
      n_checks    = 0;
      cycles      = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset();
      s_mode();
      s_soft();
      s_pin();
      s_irq();
      s_user();
      s_wdog();
      test_done();
   end
endmodule : tb_top
